/* File: hw/lcdst_pkg.sv */
// Constants, opcodes and helpers for the LCD scan timing block
package lcdst_pkg;
  localparam int unsigned SEG_N  = 132;
  localparam int unsigned COM_N  = 104;
  localparam int unsigned ROW_N  = 160;
  localparam int unsigned PAGE_N = 20;
  localparam int unsigned PAGE_H = 8;

  typedef logic [7:0]       lcdst_byte_t;
  typedef logic [SEG_N-1:0] lcdst_row_t;

  localparam logic [7:0] COL_LAST  = 8'h83;
  localparam logic [7:0] ROW_LAST  = 8'h9f;
  localparam logic [7:0] ROW_COUNT = 8'ha0;
  localparam logic [7:0] OSC_DIV   = 8'h64;
  localparam logic [7:0] DUTY_STEP = 8'h08;

  // Full opcodes
  localparam logic [7:0] OP_DISP     = 8'hae;
  localparam logic [7:0] OP_INVERSE  = 8'ha6;
  localparam logic [7:0] OP_STATIC   = 8'ha4;
  localparam logic [7:0] OP_SUB_IN   = 8'h70;
  localparam logic [7:0] OP_SUB_OUT  = 8'h71;
  localparam logic [7:0] OP_NL_EXEC  = 8'h70;
  localparam logic [7:0] OP_LSB_MASK = 8'hfe;
  // Opcode high nibbles
  localparam logic [3:0] NIB_COL_LO   = 4'h0;
  localparam logic [3:0] NIB_COL_HI   = 4'h1;
  localparam logic [3:0] NIB_POWER    = 4'h2;
  localparam logic [3:0] NIB_BOOST    = 4'h3;
  localparam logic [3:0] NIB_PAGE_HI  = 4'h4;
  localparam logic [3:0] NIB_START_HI = 4'h5;
  localparam logic [3:0] NIB_START_LO = 4'h6;
  localparam logic [3:0] NIB_PAGE_LO  = 4'hc;
  localparam logic [3:0] NIB_DUTY     = 4'hf;
  localparam logic [3:0] NIB_NL_HI    = 4'h5;
  localparam logic [3:0] NIB_NL_LO    = 4'h6;

  // Reset values
  localparam logic [7:0] START_RST = 8'h00;
  localparam logic [3:0] DUTY_RST  = 4'hc;
  localparam logic [1:0] BOOST_RST = 2'h3;
  localparam logic [5:0] NLINE_RST = 6'h00;
  localparam logic [4:0] PAGE_RST  = 5'h00;
  localparam logic [7:0] COL_RST   = 8'h00;
  localparam logic [2:0] BOOST_BASE = 3'h2;

  // Status byte bit positions
  localparam int unsigned ST_BUSY = 7;
  localparam int unsigned ST_ON   = 5;
  localparam int unsigned ST_PWR  = 4;

  // Oscillator periods per display clock for a duty code
  function automatic logic [5:0] cl_divide(input logic [3:0] k);
    logic [5:0] d;
    d = 6'h04;
    unique case (k)
      4'h0:        d = 6'h32;
      4'h1:        d = 6'h19;
      4'h2:        d = 6'h10;
      4'h3:        d = 6'h0c;
      4'h4:        d = 6'h0a;
      4'h5, 4'h6:  d = 6'h08;
      4'h7, 4'h8:  d = 6'h06;
      4'h9, 4'ha:  d = 6'h05;
      default:     d = 6'h04;
    endcase
    return d;
  endfunction

  // Frame memory row for a scan line, wrapping at the last row
  function automatic logic [7:0] row_of(input logic [7:0] start,
                                        input logic [7:0] line);
    logic [8:0] s;
    s = {1'b0, start} + {1'b0, line};
    if (s >= {1'b0, ROW_COUNT}) s = s - {1'b0, ROW_COUNT};
    // A start line and scan line summing to 320 or more need a second wrap
    if (s >= {1'b0, ROW_COUNT}) s = s - {1'b0, ROW_COUNT};
    return s[7:0];
  endfunction
endpackage

/* File: hw/lcdst_mem_if.sv */
// Carrier between the scan logic and the frame memory
`timescale 1ns/1ps
interface lcdst_mem_if;
  import lcdst_pkg::*;
  logic        h_we;
  logic        h_re;
  logic        h_status_sel;
  logic [4:0]  h_page;
  logic [7:0]  h_col;
  lcdst_byte_t h_wdata;
  lcdst_byte_t h_status;
  lcdst_byte_t h_q;
  logic        s_re;
  logic [7:0]  s_row;
  lcdst_row_t  s_q;
  modport ctrl (output h_we, h_re, h_status_sel, h_page, h_col, h_wdata,
                h_status, s_re, s_row, input h_q, s_q);
  modport mem  (input h_we, h_re, h_status_sel, h_page, h_col, h_wdata,
                h_status, s_re, s_row, output h_q, s_q);
endinterface

/* File: hw/lcdst_mem.sv */
// Frame memory: byte port for the host, row port for refresh
`timescale 1ns/1ps
module lcdst_mem (
  input  wire logic I_CLOCK,
  input  wire logic I_RST,
  lcdst_mem_if.mem  bus
);
  import lcdst_pkg::*;

  lcdst_byte_t mem [PAGE_N][SEG_N];

  always_ff @(posedge I_CLOCK) begin
    if (bus.h_we) begin
      mem[bus.h_page][bus.h_col] <= bus.h_wdata;
    end
  end

  // Host read register also carries the status byte
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      bus.h_q <= '0;
    end else if (bus.h_re) begin
      bus.h_q <= bus.h_status_sel ? bus.h_status
                                  : mem[bus.h_page][bus.h_col];
    end
  end

  // Row gather for refresh, a port of its own
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      bus.s_q <= '0;
    end else if (bus.s_re) begin
      for (int c = 0; c < SEG_N; c++) begin
        bus.s_q[c] <= mem[bus.s_row[7:3]][c][bus.s_row[2:0]];
      end
    end
  end
endmodule

/* File: hw/lcdst_top.sv */
// LCD scan timing, instruction decode and supply mode control
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module lcdst_top (
  input  wire logic                 I_CLOCK,
  input  wire logic                 I_RST,
  input  wire logic                 I_ADDR,
  input  wire lcdst_pkg::lcdst_byte_t I_WDATA,
  input  wire logic                 I_WR,
  input  wire logic                 I_RD,
  output logic [7:0]                O_RDATA,
  input  wire logic                 I_SER_SEL,
  input  wire logic                 I_SER_SHIFT,
  input  wire logic                 I_SER_DATA,
  input  wire logic                 I_SUPPLY_MODE_PIN_A,
  input  wire logic                 I_SUPPLY_MODE_PIN_B,
  output logic [lcdst_pkg::SEG_N-1:0] O_SEG,
  output logic [lcdst_pkg::COM_N-1:0] O_COM,
  output logic                      O_FRAME_ALTERNATION_SIGNAL,
  output logic                      O_ROW_SCAN_CLOCK,
  output logic                      O_BOOST_CLK,
  output logic                      O_BOOST_EN,
  output logic                      O_REG_EN,
  output logic                      O_FOLLOW_EN,
  output logic [2:0]                O_BOOST_FACTOR
);
  import lcdst_pkg::*;

  lcdst_mem_if mif ();

  lcdst_mem u_mem (
    .I_CLOCK (I_CLOCK),
    .I_RST   (I_RST),
    .bus     (mif.mem)
  );

  // Serial shifter
  logic [2:0]  ser_cnt_r;
  lcdst_byte_t ser_sh_r;
  logic        ser_done_r;
  logic        ser_a0_r;

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      ser_cnt_r  <= '0;
      ser_sh_r   <= '0;
      ser_done_r <= 1'b0;
      ser_a0_r   <= 1'b0;
    end else begin
      ser_done_r <= 1'b0;
      if (!I_SER_SEL) begin
        ser_cnt_r <= '0;
      end else if (I_SER_SHIFT) begin
        ser_sh_r  <= {ser_sh_r[6:0], I_SER_DATA};
        ser_cnt_r <= ser_cnt_r + 3'h1;
        if (ser_cnt_r == 3'h7) begin
          ser_done_r <= 1'b1;
          ser_a0_r   <= I_ADDR;
        end
      end
    end
  end

  // Transfer decode; parallel write wins over a serial byte
  logic        host_wr;
  logic        host_a0;
  lcdst_byte_t host_d;
  logic        cmd_wr;
  logic        dat_wr;
  logic        dat_rd;

  always_comb begin
    host_wr = I_WR | ser_done_r;
    host_a0 = I_WR ? I_ADDR : ser_a0_r;
    host_d  = I_WR ? I_WDATA : ser_sh_r;
    cmd_wr  = host_wr & ~host_a0;
    dat_wr  = host_wr & host_a0;
    dat_rd  = I_RD & I_ADDR & ~I_WR;
  end

  // Settings written by instructions
  logic        disp_on_r;
  logic        reverse_r;
  logic        static_r;
  logic        power_r;
  logic        sub_r;
  logic [1:0]  boost_r;
  logic [3:0]  duty_r;
  logic [7:0]  start_r;
  logic [4:0]  page_r;
  logic [7:0]  col_r;
  logic [5:0]  nl_set_r;
  logic [5:0]  nline_r;
  logic [3:0]  op_nib;

  assign op_nib = host_d[7:4];

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      disp_on_r <= 1'b0;
      reverse_r <= 1'b0;
      static_r  <= 1'b0;
      power_r   <= 1'b0;
      sub_r     <= 1'b0;
      boost_r   <= BOOST_RST;
      duty_r    <= DUTY_RST;
      start_r   <= START_RST;
      nl_set_r  <= NLINE_RST;
      nline_r   <= NLINE_RST;
    end else if (cmd_wr) begin
      if (sub_r) begin
        if (host_d == OP_SUB_OUT) sub_r <= 1'b0;
        else if (host_d == OP_NL_EXEC) nline_r <= nl_set_r;
        else if (op_nib == NIB_NL_HI) nl_set_r[5:4] <= host_d[1:0];
        else if (op_nib == NIB_NL_LO) nl_set_r[3:0] <= host_d[3:0];
      end else if ((host_d & OP_LSB_MASK) == OP_DISP) begin
        disp_on_r <= host_d[0];
      end else if ((host_d & OP_LSB_MASK) == OP_INVERSE) begin
        reverse_r <= host_d[0];
      end else if ((host_d & OP_LSB_MASK) == OP_STATIC) begin
        static_r <= host_d[0];
      end else if (host_d == OP_SUB_IN) begin
        sub_r <= 1'b1;
      end else if (op_nib == NIB_START_HI) begin
        start_r[7:4] <= host_d[3:0];
      end else if (op_nib == NIB_START_LO) begin
        start_r[3:0] <= host_d[3:0];
      end else if (op_nib == NIB_POWER) begin
        power_r <= host_d[0];
      end else if (op_nib == NIB_BOOST) begin
        boost_r <= host_d[1:0];
      end else if (op_nib == NIB_DUTY) begin
        duty_r <= (host_d[3:0] > DUTY_RST) ? DUTY_RST : host_d[3:0];
      end
    end
  end

  // Column counter freezes at the last column; page register
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      page_r <= PAGE_RST;
      col_r  <= COL_RST;
    end else if (cmd_wr && !sub_r && op_nib == NIB_PAGE_HI) begin
      page_r[4] <= host_d[0];
    end else if (cmd_wr && !sub_r && op_nib == NIB_PAGE_LO) begin
      page_r[3:0] <= host_d[3:0];
    end else if (cmd_wr && !sub_r && op_nib == NIB_COL_HI) begin
      col_r[7:4] <= host_d[3:0];
    end else if (cmd_wr && !sub_r && op_nib == NIB_COL_LO) begin
      col_r[3:0] <= host_d[3:0];
    end else if ((dat_wr || dat_rd) && col_r < COL_LAST) begin
      col_r <= col_r + 8'h01;
    end
  end

  // Oscillator tick and display clock divider
  logic [7:0] osc_cnt_r;
  logic       osc_en_r;
  logic [5:0] cl_cnt_r;
  logic       cl_en_r;

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      osc_cnt_r <= '0;
      osc_en_r  <= 1'b0;
    end else begin
      osc_en_r  <= (osc_cnt_r == OSC_DIV - 8'h01);
      osc_cnt_r <= (osc_cnt_r == OSC_DIV - 8'h01) ? 8'h00
                                                  : osc_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      cl_cnt_r <= '0;
      cl_en_r  <= 1'b0;
    end else begin
      cl_en_r <= 1'b0;
      if (osc_en_r) begin
        if (cl_cnt_r >= cl_divide(duty_r) - 6'h01) begin
          cl_cnt_r <= '0;
          cl_en_r  <= 1'b1;
        end else begin
          cl_cnt_r <= cl_cnt_r + 6'h01;
        end
      end
    end
  end

  // Line counter, frame toggle and n-line phase
  logic [7:0] line_r;
  logic [7:0] duty_lines;
  logic       last_line;
  logic       frame_r;
  logic       nl_phase_r;
  logic [5:0] nl_cnt_r;

  always_comb begin
    duty_lines = ({4'h0, duty_r} + 8'h01) * DUTY_STEP;
    // Also catches a line count left above a newly shortened duty
    last_line  = (line_r >= duty_lines - 8'h01);
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      line_r  <= '0;
      frame_r <= 1'b0;
    end else if (cl_en_r) begin
      if (last_line) begin
        frame_r <= ~frame_r;
        line_r  <= '0;
      end else begin
        line_r  <= line_r + 8'h01;
      end
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      nl_cnt_r   <= '0;
      nl_phase_r <= 1'b0;
    end else if (cl_en_r) begin
      if (last_line || nline_r == NLINE_RST) begin
        nl_cnt_r   <= '0;
        nl_phase_r <= 1'b0;
      end else if (nl_cnt_r == nline_r - 6'h01) begin
        nl_cnt_r   <= '0;
        nl_phase_r <= ~nl_phase_r;
      end else begin
        nl_cnt_r <= nl_cnt_r + 6'h01;
      end
    end
  end

  // Frame memory hookup
  always_comb begin
    mif.h_we         = dat_wr;
    mif.h_re         = I_RD;
    mif.h_status_sel = ~I_ADDR;
    mif.h_page       = page_r;
    mif.h_col        = col_r;
    mif.h_wdata      = host_d;
    mif.h_status     = '0;
    mif.h_status[ST_ON]  = disp_on_r;
    mif.h_status[ST_PWR] = power_r;
    mif.s_re         = cl_en_r;
    mif.s_row        = row_of(start_r, line_r);
  end

  assign O_RDATA = mif.h_q;

  // Drive stage: one cycle after the fetch
  logic             lat_r;
  logic             first_r;
  logic [COM_N-1:0] com_sh_r;
  logic [COM_N-1:0] com_sh_nxt;

  // First line restarts the pattern; commons beyond the duty stay off
  always_comb begin
    com_sh_nxt = {com_sh_r[COM_N-2:0], first_r};
    if (first_r) com_sh_nxt[COM_N-1:1] = '0;
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      lat_r   <= 1'b0;
      first_r <= 1'b0;
    end else begin
      lat_r   <= cl_en_r;
      if (cl_en_r) first_r <= (line_r == 8'h00);
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      com_sh_r <= '0;
      O_COM    <= '0;
      O_SEG    <= '0;
      O_FRAME_ALTERNATION_SIGNAL <= 1'b0;
      O_ROW_SCAN_CLOCK <= 1'b0;
    end else begin
      O_ROW_SCAN_CLOCK <= lat_r;
      if (lat_r) begin
        com_sh_r <= com_sh_nxt;
        O_COM    <= disp_on_r ? com_sh_nxt : '0;
        if (!disp_on_r) O_SEG <= '0;
        else if (static_r) O_SEG <= '1;
        else O_SEG <= reverse_r ? ~mif.s_q : mif.s_q;
        O_FRAME_ALTERNATION_SIGNAL <= frame_r ^ nl_phase_r;
      end
    end
  end

  // Supply stages and booster clock
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_BOOST_EN     <= 1'b0;
      O_REG_EN       <= 1'b0;
      O_FOLLOW_EN    <= 1'b0;
      O_BOOST_CLK    <= 1'b0;
      O_BOOST_FACTOR <= BOOST_BASE + {1'b0, BOOST_RST};
    end else begin
      O_BOOST_EN  <= power_r & ~I_SUPPLY_MODE_PIN_A;
      O_REG_EN    <= power_r & ~(I_SUPPLY_MODE_PIN_A
                                 & I_SUPPLY_MODE_PIN_B);
      O_FOLLOW_EN <= power_r;
      if (osc_en_r) O_BOOST_CLK <= ~O_BOOST_CLK;
      O_BOOST_FACTOR <= BOOST_BASE + {1'b0, boost_r};
    end
  end
endmodule

/* File: bench/lcdst_props.sv */
// Checker on the top ports of the LCD scan timing block
`timescale 1ns/1ps
module lcdst_props (
  input wire logic                        I_CLOCK,
  input wire logic                        I_RST,
  input wire logic                        I_ADDR,
  input wire logic                        I_RD,
  input wire logic [7:0]                  O_RDATA,
  input wire logic                        I_SUPPLY_MODE_PIN_A,
  input wire logic [lcdst_pkg::SEG_N-1:0] O_SEG,
  input wire logic [lcdst_pkg::COM_N-1:0] O_COM,
  input wire logic                        O_FRAME_ALTERNATION_SIGNAL,
  input wire logic                        O_ROW_SCAN_CLOCK,
  input wire logic                        O_BOOST_CLK,
  input wire logic                        O_BOOST_EN,
  input wire logic                        O_REG_EN,
  input wire logic                        O_FOLLOW_EN,
  input wire logic [2:0]                  O_BOOST_FACTOR
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  property p_com_hot; $onehot0(O_COM); endproperty
  property p_com_step;
    $changed(O_COM) && $past(O_COM) != '0 && O_COM != '0
      |-> O_COM[0] || O_COM == ($past(O_COM) << 1);
  endproperty
  property p_seg_line; $changed(O_SEG) |-> O_ROW_SCAN_CLOCK; endproperty
  property p_fr_line;
    $changed(O_FRAME_ALTERNATION_SIGNAL) |-> O_ROW_SCAN_CLOCK;
  endproperty
  property p_scan_gap; O_ROW_SCAN_CLOCK |=> (!O_ROW_SCAN_CLOCK)[*8];
  endproperty
  property p_boost_clk;
    $changed(O_BOOST_CLK)
      |=> $stable(O_BOOST_CLK)[*8] ##92 $changed(O_BOOST_CLK);
  endproperty
  property p_supply;
    (!O_BOOST_EN || O_REG_EN) && (!O_REG_EN || O_FOLLOW_EN);
  endproperty
  property p_pin_a;
    $past(I_SUPPLY_MODE_PIN_A) && $past(I_SUPPLY_MODE_PIN_A, 2)
      |-> !O_BOOST_EN;
  endproperty
  property p_factor; O_BOOST_FACTOR inside {[3'h2:3'h5]}; endproperty
  property p_status; I_RD && !I_ADDR |=> (O_RDATA & 8'hcf) == 8'h00;
  endproperty
  property p_rd_hold; !$past(I_RD) |-> $stable(O_RDATA); endproperty
  a_com_hot: assert property (p_com_hot)
    else $error("common select not one-hot");
  a_com_step: assert property (p_com_step)
    else $error("common select skipped a line");
  a_seg_line: assert property (p_seg_line)
    else $error("segments changed off the line event");
  a_fr_line: assert property (p_fr_line)
    else $error("polarity changed off the line event");
  a_scan_gap: assert property (p_scan_gap)
    else $error("row clock pulses too close");
  a_boost_clk: assert property (p_boost_clk)
    else $error("booster clock period wrong");
  a_supply: assert property (p_supply)
    else $error("supply stage enables inconsistent");
  a_pin_a: assert property (p_pin_a)
    else $error("booster on with mode pin a high");
  a_factor: assert property (p_factor)
    else $error("booster factor out of range");
  a_status: assert property (p_status)
    else $error("status reserved or busy bit set");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  c_first: cover property (O_ROW_SCAN_CLOCK && O_COM[0]);
  c_frame: cover property ($changed(O_FRAME_ALTERNATION_SIGNAL));
  c_boost: cover property (O_BOOST_EN && O_REG_EN);
endmodule
bind lcdst_top lcdst_props u_props (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
  .I_ADDR(I_ADDR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_SEG(O_SEG),
  .I_SUPPLY_MODE_PIN_A(I_SUPPLY_MODE_PIN_A), .O_COM(O_COM),
  .O_FRAME_ALTERNATION_SIGNAL(O_FRAME_ALTERNATION_SIGNAL),
  .O_ROW_SCAN_CLOCK(O_ROW_SCAN_CLOCK), .O_BOOST_CLK(O_BOOST_CLK),
  .O_BOOST_EN(O_BOOST_EN), .O_REG_EN(O_REG_EN),
  .O_FOLLOW_EN(O_FOLLOW_EN), .O_BOOST_FACTOR(O_BOOST_FACTOR));

/* File: bench/lcdst_panel.sv */
// Panel model: keeps the row and common of the last scan pulse
`timescale 1ns/1ps
module lcdst_panel (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic [lcdst_pkg::SEG_N-1:0] i_seg,
  input  wire logic [lcdst_pkg::COM_N-1:0] i_com,
  input  wire logic                        i_scan,
  output lcdst_pkg::lcdst_row_t            o_row,
  output int                               o_com_idx
);
  import lcdst_pkg::*;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_row <= '0;
      o_com_idx <= -1;
    end else if (i_scan) begin
      o_row <= i_seg;
      o_com_idx <= -1;
      for (int k = 0; k < COM_N; k++) begin
        if (i_com[k] === 1'b1) o_com_idx <= k;
      end
    end
  end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the LCD scan timing block
`timescale 1ns/1ps
module testbench;
  import lcdst_pkg::*;
  logic             clk, rst, addr, wstb, rstb, ssel, sshift, sdata, pa, pb;
  logic             fr, scan, bclk, ben, ren, fen;
  lcdst_byte_t      wdata, rdata, b;
  logic [SEG_N-1:0] seg;
  logic [COM_N-1:0] com;
  logic [2:0]       bfac;
  lcdst_row_t       p_row;
  int               p_com, miscompares, total_checks, cycles, n;
  lcdst_top uut (.I_CLOCK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wstb), .I_RD(rstb), .O_RDATA(rdata), .I_SER_SEL(ssel),
    .I_SER_SHIFT(sshift), .I_SER_DATA(sdata), .I_SUPPLY_MODE_PIN_A(pa),
    .I_SUPPLY_MODE_PIN_B(pb), .O_SEG(seg), .O_COM(com),
    .O_FRAME_ALTERNATION_SIGNAL(fr), .O_ROW_SCAN_CLOCK(scan),
    .O_BOOST_CLK(bclk), .O_BOOST_EN(ben), .O_REG_EN(ren),
    .O_FOLLOW_EN(fen), .O_BOOST_FACTOR(bfac));
  lcdst_panel u_panel (.i_clk(clk), .i_rst(rst), .i_seg(seg), .i_com(com),
    .i_scan(scan), .o_row(p_row), .o_com_idx(p_com));
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_row(lcdst_row_t got, lcdst_row_t exp, string m);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s row", $time, m);
    end
  endtask
  task automatic bus_wr(logic a, lcdst_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstb <= 1'b1;
    @(posedge clk);
    wstb <= 1'b0;
  endtask
  task automatic bus_rd(logic a, output lcdst_byte_t d);
    @(posedge clk);
    addr <= a;
    rstb <= 1'b1;
    @(posedge clk);
    rstb <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic cmd(lcdst_byte_t d);
    bus_wr(1'b0, d);
  endtask
  // Cycles up to the next row clock pulse
  task automatic wait_line(output int k);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (scan !== 1'b1 && k < 12000);
    @(negedge clk);
  endtask
  function automatic lcdst_byte_t pat(int c);
    return 8'(c) ^ 8'h96;
  endfunction
  function automatic lcdst_row_t exp_row(int r);
    lcdst_row_t  e;
    lcdst_byte_t v;
    for (int c = 0; c < SEG_N; c++) begin
      v = pat(c);
      e[c] = v[r];
    end
    return e;
  endfunction
  task automatic t_reset();
    chk(bfac, 5, "reset factor");
    chk({ben, ren, fen}, 0, "reset supply");
    chk_row(132'(com), '0, "reset common");
    bus_rd(1'b0, b);
    chk(b, 0, "reset status");
  endtask
  task automatic t_supply();
    cmd(8'h21);
    for (int m = 0; m < 4; m++) begin
      pa <= m[1];
      pb <= m[0];
      repeat (3) @(posedge clk);
      chk({ben, ren, fen}, {!m[1], !(m[1] && m[0]), 1'b1}, "mode");
    end
    bus_rd(1'b0, b);
    chk(b, 8'h10, "status supply");
    cmd(8'h20);
    repeat (3) @(posedge clk);
    chk({ben, ren, fen}, 0, "supply off");
    pa <= 1'b0;
    pb <= 1'b0;
  endtask
  task automatic t_boost();
    for (int k = 0; k < 4; k++) begin
      cmd(8'(8'h30 | k));
      repeat (2) @(posedge clk);
      chk(bfac, 2 + k, "factor");
    end
    b[0] = bclk;
    repeat (OSC_DIV) @(posedge clk);
    chk(bclk, !b[0], "booster clock");
  endtask
  task automatic t_scan();
    logic f;
    cmd(8'h40);
    cmd(8'hc0);
    cmd(8'h10);
    cmd(8'h00);
    for (int c = 0; c < SEG_N; c++) bus_wr(1'b1, pat(c));
    cmd(8'h50);
    cmd(8'h61);
    cmd(8'haf);
    bus_rd(1'b0, b);
    chk(b, 8'h20, "status on");
    f = fr;
    n = 0;
    while (fr === f && n < 45000) begin
      @(posedge clk);
      n++;
    end
    wait_line(n);
    chk(p_com, 0, "first common");
    chk_row(p_row, exp_row(1), "start");
    wait_line(n);
    chk(n, 400, "line period");
    chk(p_com, 1, "second common");
    chk_row(seg, exp_row(2), "normal");
    cmd(8'ha7);
    wait_line(n);
    chk_row(seg, ~exp_row(3), "reverse");
    cmd(8'ha6);
    cmd(8'ha5);
    wait_line(n);
    chk_row(seg, '1, "static");
    cmd(8'ha4);
    cmd(8'hae);
    wait_line(n);
    chk_row(seg, '0, "off");
    chk_row(132'(com), '0, "off common");
    cmd(8'h10);
    cmd(8'h00);
    for (int c = 0; c < SEG_N; c++) begin
      bus_rd(1'b1, b);
      chk(b, pat(c), "memory kept");
    end
  endtask
  task automatic t_serial();
    logic [7:0] d;
    d = 8'hc1;
    cmd(8'h10);
    cmd(8'h00);
    addr <= 1'b1;
    ssel <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      sdata <= d[i];
      sshift <= 1'b1;
      @(posedge clk);
      sshift <= 1'b0;
    end
    repeat (2) @(posedge clk);
    ssel <= 1'b0;
    cmd(8'h10);
    cmd(8'h00);
    bus_rd(1'b1, b);
    chk(b, d, "serial byte");
  endtask
  task automatic t_duty();
    int code[9] = '{0, 1, 2, 3, 4, 5, 7, 9, 12};
    int dv[9] = '{50, 25, 16, 12, 10, 8, 6, 5, 4};
    for (int i = 0; i < 9; i++) begin
      cmd(8'(8'hf0 | code[i]));
      wait_line(n);
      wait_line(n);
      chk(n, 100 * dv[i], "duty divide");
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    {rst, addr, wstb, rstb, ssel, sshift, sdata, pa, pb} = 9'h100;
    wdata = 8'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_supply();
    t_boost();
    t_scan();
    t_serial();
    t_duty();
    conclude();
  end
endmodule
